// file: logic/eeprom_autoload_config.sv
// Autoloader that copies a serial configuration EEPROM into SRAM.
// Assumes an APB master on pclk and the EEPROM on three pins.

`timescale 1ns/1ps
`default_nettype none

module eeprom_autoload_config #(
	parameter int EE_AW = 8, // EEPROM word address bits
	parameter int APB_AW = 12
) (
	input wire logic pclk,
	input wire logic presetn, // Active-low hardware reset
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cfgmem_select_n, // Chip select, low active
	output logic cfgmem_serial_clk,
	output logic cfgmem_serial_io_o,
	output logic cfgmem_serial_io_oe,
	input wire logic cfgmem_serial_io_i,
	input wire logic [1:0] bus_type_strap, // Power-on strap pins
	output eeprom_autoload_pkg::sram_wr_t sram_wr,
	output eeprom_autoload_pkg::link_cfg_t link_cfg,
	output logic load_done
);

	localparam int CMD_BITS = 3 + EE_AW; // Start, opcode, address
	localparam int DUMMY_BITS_L = eeprom_autoload_pkg::DUMMY_BITS;
	localparam int DATA_BITS_L = eeprom_autoload_pkg::DATA_BITS;
	localparam int FRAME_BITS = CMD_BITS + DUMMY_BITS_L + DATA_BITS_L;
	localparam logic [7:0] HALF_M1 = 8'(eeprom_autoload_pkg::EE_HALF_CYC - 1);

	// Frame must fit the shift and bit counters
	if (EE_AW < 6 || EE_AW > 8) begin : g_bad_aw
		$error("EE_AW must lie between 6 and 8");
	end
	// The range check reads address bits from 10 upwards
	if (APB_AW < 11) begin : g_bad_apb
		$error("APB_AW must be at least 11");
	end

	eeprom_autoload_pkg::state_t s_ff; // Registered state
	eeprom_autoload_pkg::state_t nxt_s; // Next state
	logic adv; // Current word handled, move on
	logic [7:0] nxt_addr; // Following EEPROM word
	logic [15:0] cnt_now; // Word count in force
	logic last_word; // No more words to read
	logic [1:0] mac_i; // Station address word index
	logic [7:0] reg_idx; // APB register index
	logic addr_ok; // Aligned, in range

	// Fixed part of the SRAM image after the address words
	function automatic eeprom_autoload_pkg::sram_wr_t fill_entry(
		input logic [3:0] idx,
		input logic leg
	);
		eeprom_autoload_pkg::sram_wr_t w;
		logic [7:0] b;
		w.we = 1'b1;
		w.data = 16'h0000;
		b = leg ? eeprom_autoload_pkg::LEGACY_SET : eeprom_autoload_pkg::LEGACY_CLR;
		if (idx < 4'h6) begin
			// Zero words 10h-1Ah
			w.addr = eeprom_autoload_pkg::LOW_ZERO_BASE + {11'h000, idx, 1'b0};
		end else if (idx < 4'h8) begin
			// Signature bytes 1Ch-1Fh
			w.addr = eeprom_autoload_pkg::LEGACY_ADDR + {11'h000, 4'(idx - 4'h6), 1'b0}; // RQ12
			w.data = {b, b}; // RQ12
		end else if (idx < eeprom_autoload_pkg::FILL_LAST) begin
			// Zero words 0406h-040Ch
			w.addr = eeprom_autoload_pkg::HIGH_ZERO_BASE + {11'h000, 4'(idx - 4'h8), 1'b0};
		end else begin
			w.addr = eeprom_autoload_pkg::HIGH_TAIL_ADDR;
			w.data = eeprom_autoload_pkg::HIGH_TAIL_DATA;
		end
		return w;
	endfunction

	// Open a read frame: select, start bit out first
	function automatic eeprom_autoload_pkg::state_t start_read(
		input eeprom_autoload_pkg::state_t x,
		input logic [7:0] a
	);
		eeprom_autoload_pkg::state_t y;
		y = x;
		y.tx = {eeprom_autoload_pkg::READ_OP, a};
		if (EE_AW < 8) begin
			y.tx = y.tx << (8 - EE_AW);
		end
		y.rd_addr = a;
		y.cs_n = 1'b0; // RQ16
		y.sclk = 1'b0; // RQ17
		y.io_o = 1'b1;
		y.io_oe = 1'b1; // RQ18
		y.phase = 1'b0;
		y.bit_idx = 6'h00;
		y.div = HALF_M1;
		y.st = eeprom_autoload_pkg::ST_XFER;
		return y;
	endfunction

	// Word sequencing helpers
	always_comb begin
		nxt_addr = 8'(s_ff.rd_addr + 8'h01);
		cnt_now = (s_ff.rd_addr == eeprom_autoload_pkg::CNT_ADDR) ? s_ff.rx : s_ff.count; // RQ7
		// Word 0 always leads to word 1; an address wrap ends the load
		last_word = (s_ff.rd_addr != eeprom_autoload_pkg::SIG_ADDR) &&
			(({8'h00, nxt_addr} >= cnt_now) || (nxt_addr == 8'h00) ||
			(EE_AW < 8 && nxt_addr[7:(EE_AW < 8 ? EE_AW : 7)] != '0)); // RQ7
		mac_i = 2'(s_ff.rd_addr - eeprom_autoload_pkg::MAC_FIRST);
		reg_idx = paddr[9:2];
		addr_ok = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:10] == '0);
	end

	// Next-state logic for loader, pins and registers
	always_comb begin
		nxt_s = s_ff;
		adv = 1'b0;
		nxt_s.wr.we = 1'b0;
		nxt_s.pready = 1'b0;
		// Two-stage synchronisers for pin inputs
		nxt_s.din_s1 = cfgmem_serial_io_i;
		nxt_s.din_s2 = s_ff.din_s1;
		nxt_s.strap_s1 = bus_type_strap;
		nxt_s.strap_s2 = s_ff.strap_s1;
		// Effective interrupt settings
		nxt_s.cfg.irq_type = s_ff.irq_output_type_init | s_ff.bus_type_config_reg_type; // RQ10
		nxt_s.cfg.irq_pol = s_ff.irq_polarity_init | s_ff.bus_type_config_reg_pol; // RQ11
		case (s_ff.st)
			eeprom_autoload_pkg::ST_START: begin
				// Wait for the strap synchroniser, then latch and load
				if (s_ff.div == 8'(eeprom_autoload_pkg::SYNC_DEPTH)) begin
					nxt_s.cfg.bus_type = s_ff.strap_s2; // RQ19
					nxt_s = start_read(nxt_s, eeprom_autoload_pkg::SIG_ADDR); // RQ2 RQ5
				end else begin
					nxt_s.div = 8'(s_ff.div + 8'h01);
				end
			end
			eeprom_autoload_pkg::ST_XFER: begin
				if (s_ff.div != 8'h00) begin
					nxt_s.div = 8'(s_ff.div - 8'h01);
				end else if (!s_ff.phase) begin
					// Rising serial clock
					nxt_s.div = HALF_M1;
					nxt_s.phase = 1'b1;
					nxt_s.sclk = 1'b1; // RQ17
				end else begin
					// Falling clock; capture data bits late in the high half
					nxt_s.div = HALF_M1;
					nxt_s.phase = 1'b0;
					nxt_s.sclk = 1'b0;
					if (s_ff.bit_idx >= 6'(CMD_BITS + DUMMY_BITS_L)) begin
						nxt_s.rx = {s_ff.rx[14:0], s_ff.din_s2}; // RQ18
					end
					if (s_ff.bit_idx == 6'(FRAME_BITS - 1)) begin
						nxt_s.cs_n = 1'b1; // RQ16
						nxt_s.st = eeprom_autoload_pkg::ST_GAP;
					end else begin
						nxt_s.bit_idx = 6'(s_ff.bit_idx + 6'h01);
						nxt_s.tx = {s_ff.tx[9:0], 1'b0};
						nxt_s.io_o = s_ff.tx[9];
						// Release the line once the command is out
						nxt_s.io_oe = (s_ff.bit_idx < 6'(CMD_BITS - 1)); // RQ18
					end
				end
			end
			eeprom_autoload_pkg::ST_GAP: begin
				// Deselect time, then act on the word
				if (s_ff.div != 8'h00) begin
					nxt_s.div = 8'(s_ff.div - 8'h01);
				end else if (s_ff.rd_addr == eeprom_autoload_pkg::SIG_ADDR) begin
					if (s_ff.rx != eeprom_autoload_pkg::SIG_WORD) begin
						// Absent or blank part: stop, keep defaults
						nxt_s.cfg.sig_ok = 1'b0; // RQ6
						nxt_s.done = 1'b1; // RQ14
						nxt_s.st = eeprom_autoload_pkg::ST_DONE; // RQ14
					end else begin
						nxt_s.cfg.sig_ok = 1'b1; // RQ5
						adv = 1'b1;
					end
				end else if (s_ff.rd_addr == eeprom_autoload_pkg::CNT_ADDR) begin
					nxt_s.count = s_ff.rx; // RQ7
					adv = 1'b1;
				end else if (s_ff.rd_addr == eeprom_autoload_pkg::CFG_ADDR) begin
					nxt_s.cfg.phy_mode = s_ff.rx[eeprom_autoload_pkg::PHY_MODE_LSB +: 3]; // RQ8 RQ9
					nxt_s.irq_output_type_init = s_ff.rx[eeprom_autoload_pkg::IRQ_TYPE_BIT]; // RQ10
					nxt_s.irq_polarity_init = s_ff.rx[eeprom_autoload_pkg::IRQ_POL_BIT]; // RQ11
					nxt_s.cfg.legacy_sig_select = s_ff.rx[eeprom_autoload_pkg::LEGACY_BIT]; // RQ12
					adv = 1'b1;
				end else if (s_ff.rd_addr >= eeprom_autoload_pkg::MAC_FIRST &&
					s_ff.rd_addr <= eeprom_autoload_pkg::MAC_LAST) begin
					nxt_s.sub = 2'b00;
					nxt_s.st = eeprom_autoload_pkg::ST_MAC;
				end else begin
					// Words past the address image are read and dropped
					adv = 1'b1;
				end
			end
			eeprom_autoload_pkg::ST_MAC: begin
				// Three SRAM writes per address word; never the station registers
				nxt_s.wr.we = 1'b1; // RQ3
				if (s_ff.sub == 2'b00) begin
					nxt_s.wr.addr = eeprom_autoload_pkg::HIGH_BASE + {13'h0000, mac_i, 1'b0}; // RQ13
					nxt_s.wr.data = s_ff.rx; // RQ13
				end else begin
					nxt_s.wr.addr = eeprom_autoload_pkg::LOW_BASE + {12'h000, mac_i, s_ff.sub[1], 1'b0};
					// Each address byte is doubled into both lanes
					nxt_s.wr.data = s_ff.sub[1] ? {2{s_ff.rx[15:8]}} : {2{s_ff.rx[7:0]}}; // RQ13
				end
				nxt_s.sub = 2'(s_ff.sub + 2'b01);
				adv = (s_ff.sub == 2'b10);
			end
			eeprom_autoload_pkg::ST_FILL: begin
				nxt_s.wr = fill_entry(s_ff.fill, s_ff.cfg.legacy_sig_select); // RQ2 RQ12
				nxt_s.fill = 4'(s_ff.fill + 4'h1);
				if (s_ff.fill == eeprom_autoload_pkg::FILL_LAST) begin
					// Done follows one cycle after the last SRAM write
					nxt_s.st = eeprom_autoload_pkg::ST_DONE;
				end
			end
			eeprom_autoload_pkg::ST_DONE: begin
				// Pins now follow the management register
				nxt_s.done = 1'b1; // RQ15
			end
			default: begin
				nxt_s.st = eeprom_autoload_pkg::ST_DONE;
			end
		endcase
		// Move to the next word or to the fixed image
		if (adv) begin
			if (last_word) begin
				nxt_s.fill = 4'h0;
				nxt_s.st = eeprom_autoload_pkg::ST_FILL;
			end else begin
				nxt_s = start_read(nxt_s, nxt_addr); // RQ2
			end
		end
		// APB: answer in the second access cycle (one wait state), write at the sampling edge
		if (psel && penable && !s_ff.pready) begin
			nxt_s.pready = 1'b1;
			nxt_s.pslverr = 1'b0;
			nxt_s.prdata = 32'h0000_0000;
			if (addr_ok && reg_idx == eeprom_autoload_pkg::MGMT_IDX) begin
				nxt_s.prdata[eeprom_autoload_pkg::MG_CS_N] = s_ff.cs_n;
				nxt_s.prdata[eeprom_autoload_pkg::MG_CLK] = s_ff.sclk;
				nxt_s.prdata[eeprom_autoload_pkg::MG_DOUT] = s_ff.io_o;
				nxt_s.prdata[eeprom_autoload_pkg::MG_OE] = s_ff.io_oe;
				nxt_s.prdata[eeprom_autoload_pkg::MG_DIN] = s_ff.din_s2;
				nxt_s.prdata[eeprom_autoload_pkg::MG_DONE] = s_ff.done;
				// Writes during the load are refused
				nxt_s.pslverr = pwrite && !s_ff.done; // RQ1 RQ15
			end else if (addr_ok && reg_idx == eeprom_autoload_pkg::BUS_TYPE_CONFIG_REG_IDX) begin
				nxt_s.prdata[eeprom_autoload_pkg::IRQ_TYPE_BIT] = s_ff.bus_type_config_reg_type;
				nxt_s.prdata[eeprom_autoload_pkg::IRQ_POL_BIT] = s_ff.bus_type_config_reg_pol;
			end else if (addr_ok && reg_idx == eeprom_autoload_pkg::STAT_IDX) begin
				nxt_s.prdata[9:0] = {s_ff.cfg.bus_type, s_ff.cfg.legacy_sig_select, s_ff.cfg.irq_pol,
					s_ff.cfg.irq_type, s_ff.cfg.phy_mode, s_ff.cfg.sig_ok, s_ff.done};
			end else begin
				// Unmapped or misaligned
				nxt_s.pslverr = 1'b1;
			end
		end
		if (psel && penable && s_ff.pready && pwrite && !s_ff.pslverr) begin
			if (reg_idx == eeprom_autoload_pkg::MGMT_IDX && s_ff.done) begin
				// Host bit-bangs the EEPROM once loading is over
				nxt_s.cs_n = pwdata[eeprom_autoload_pkg::MG_CS_N]; // RQ1
				nxt_s.sclk = pwdata[eeprom_autoload_pkg::MG_CLK];
				nxt_s.io_o = pwdata[eeprom_autoload_pkg::MG_DOUT];
				nxt_s.io_oe = pwdata[eeprom_autoload_pkg::MG_OE];
			end else if (reg_idx == eeprom_autoload_pkg::BUS_TYPE_CONFIG_REG_IDX) begin
				nxt_s.bus_type_config_reg_type = pwdata[eeprom_autoload_pkg::IRQ_TYPE_BIT]; // RQ10
				nxt_s.bus_type_config_reg_pol = pwdata[eeprom_autoload_pkg::IRQ_POL_BIT]; // RQ11
			end
		end
	end

	// State register; reset holds everything idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0; // RQ19
			s_ff.st <= eeprom_autoload_pkg::ST_START;
			s_ff.cs_n <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register
	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign cfgmem_select_n = s_ff.cs_n;
	assign cfgmem_serial_clk = s_ff.sclk;
	assign cfgmem_serial_io_o = s_ff.io_o;
	assign cfgmem_serial_io_oe = s_ff.io_oe;
	assign sram_wr = s_ff.wr;
	assign link_cfg = s_ff.cfg;
	assign load_done = s_ff.done; // RQ15

endmodule // eeprom_autoload_config

`default_nettype wire

// file: logic/eeprom_autoload_pkg.sv
// Constants and types for the configuration autoloader.
// Assumes a 100 MHz pclk and a three-wire serial EEPROM on the pins.
// Functional notes
// RQ1 - Host EEPROM access only after autoload completes
// RQ2 - Reset copies EEPROM into 0000h-001Fh, 0400h-040Fh
// RQ3 - Loader writes SRAM only, never station registers
// RQ4 - Host software programs the station address itself
// RQ5 - Read word 0, compare with 5AA5h
// RQ6 - Mismatch means EEPROM absent or blank
// RQ7 - Word 1 gives the total word count
// RQ8 - Word 2 bits 10:8 pick negotiation abilities
// RQ9 - Mode values 100-111 force a fixed link
// RQ10 - Word 2 bit 5 ORed with type bit
// RQ11 - Word 2 bit 4 ORed with polarity bit
// RQ12 - Bit 2 fills 1Ch-1Fh with 57h, else 42h
// RQ13 - Words 3-5 hold station address, low first
// RQ14 - Bad signature stops loading, memory untouched
// RQ15 - Done flag low while loading, blocks host
// RQ16 - Drive chip select around each serial access
// RQ17 - Drive serial clock pacing every bit
// RQ18 - One two-way pin carries both data directions
// RQ19 - Reset holds device; settings taken at release

`default_nettype none

package eeprom_autoload_pkg;

	// Clock and serial timing
	localparam int PCLK_MHZ = 100;
	localparam int EE_HALF_NS = 500; // Half period of the serial clock
	localparam int EE_HALF_CYC = (EE_HALF_NS * PCLK_MHZ + 999) / 1000;
	localparam int SYNC_DEPTH = 2;

	// Serial read frame: start bit and read opcode, address, dummy, data
	localparam logic [2:0] READ_OP = 3'h6;
	localparam int DUMMY_BITS = 1;
	localparam int DATA_BITS = 16;

	// EEPROM word layout
	localparam logic [15:0] SIG_WORD = 16'h5aa5;
	localparam logic [7:0] SIG_ADDR = 8'h00;
	localparam logic [7:0] CNT_ADDR = 8'h01;
	localparam logic [7:0] CFG_ADDR = 8'h02;
	localparam logic [7:0] MAC_FIRST = 8'h03;
	localparam logic [7:0] MAC_LAST = 8'h05;
	localparam int PHY_MODE_LSB = 8;
	localparam int IRQ_TYPE_BIT = 5;
	localparam int IRQ_POL_BIT = 4;
	localparam int LEGACY_BIT = 2;

	// Internal SRAM image
	localparam logic [15:0] LOW_BASE = 16'h0000;
	localparam logic [15:0] HIGH_BASE = 16'h0400;
	localparam logic [15:0] LOW_ZERO_BASE = 16'h0010;
	localparam logic [15:0] LEGACY_ADDR = 16'h001c;
	localparam logic [15:0] HIGH_ZERO_BASE = 16'h0406;
	localparam logic [15:0] HIGH_TAIL_ADDR = 16'h040e;
	localparam logic [15:0] HIGH_TAIL_DATA = 16'h5757;
	localparam logic [7:0] LEGACY_SET = 8'h57;
	localparam logic [7:0] LEGACY_CLR = 8'h42;
	localparam logic [3:0] FILL_LAST = 4'hc;

	// Register indices; byte address is four times the index
	localparam logic [7:0] MGMT_IDX = 8'h14;
	localparam logic [7:0] BUS_TYPE_CONFIG_REG_IDX = 8'h15;
	localparam logic [7:0] STAT_IDX = 8'h16;
	localparam int MG_CS_N = 0;
	localparam int MG_CLK = 1;
	localparam int MG_DOUT = 2;
	localparam int MG_OE = 3;
	localparam int MG_DIN = 4;
	localparam int MG_DONE = 8;

	// Loader states, one-hot
	typedef enum logic [5:0] {
		ST_START = 6'b000001,
		ST_XFER = 6'b000010,
		ST_GAP = 6'b000100,
		ST_MAC = 6'b001000,
		ST_FILL = 6'b010000,
		ST_DONE = 6'b100000
	} load_state_t;

	// SRAM write port
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] data;
	} sram_wr_t;

	// Decoded configuration
	typedef struct packed {
		logic [2:0] phy_mode;
		logic irq_type;
		logic irq_pol;
		logic legacy_sig_select;
		logic [1:0] bus_type;
		logic sig_ok;
	} link_cfg_t;

	// Whole state of the loader
	typedef struct packed {
		load_state_t st;
		logic [7:0] div;
		logic [5:0] bit_idx;
		logic phase;
		logic [10:0] tx;
		logic [15:0] rx;
		logic [7:0] rd_addr;
		logic [15:0] count;
		logic [1:0] sub;
		logic [3:0] fill;
		logic cs_n;
		logic sclk;
		logic io_o;
		logic io_oe;
		logic din_s1;
		logic din_s2;
		logic [1:0] strap_s1;
		logic [1:0] strap_s2;
		logic done;
		logic irq_output_type_init;
		logic irq_polarity_init;
		logic bus_type_config_reg_type;
		logic bus_type_config_reg_pol;
		link_cfg_t cfg;
		sram_wr_t wr;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;

endpackage

`default_nettype wire

// file: tb/eeprom_autoload_chk.sv
// Checker for the autoloader pins, SRAM writes and APB answers.
// Assumes binding to the top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module eeprom_autoload_chk #(
	parameter int APB_AW = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cfgmem_select_n,
	input wire logic cfgmem_serial_clk,
	input wire logic cfgmem_serial_io_o,
	input wire logic cfgmem_serial_io_oe,
	input wire eeprom_autoload_pkg::sram_wr_t sram_wr,
	input wire eeprom_autoload_pkg::link_cfg_t link_cfg,
	input wire logic load_done
);
	localparam int HALF = 50; // Serial half period in pclk cycles
	logic prev_clk_ff; // Serial clock one cycle back
	logic [7:0] hcnt_ff; // Cycles since the serial clock moved
	// Half-period counter; too long for a repetition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_clk_ff <= 1'b0;
			hcnt_ff <= 8'h00;
		end else begin
			prev_clk_ff <= cfgmem_serial_clk;
			hcnt_ff <= (cfgmem_serial_clk != prev_clk_ff) ? 8'h00 : hcnt_ff + 8'h01;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_clk_idle: assert property (cfgmem_select_n |-> !cfgmem_serial_clk)
		else $error("serial clock moves outside a frame");
	a_half_high: assert property ($fell(cfgmem_serial_clk) |-> hcnt_ff == HALF - 1)
		else $error("serial clock high half has wrong length");
	a_oe_frame: assert property (cfgmem_serial_io_oe |-> !cfgmem_select_n)
		else $error("data pin driven while deselected");
	a_io_steady: assert property (cfgmem_serial_clk && $past(cfgmem_serial_clk) && cfgmem_serial_io_oe
		|-> $stable(cfgmem_serial_io_o))
		else $error("data out moved in clock high half");
	a_sel_gap: assert property ($rose(cfgmem_select_n) |-> cfgmem_select_n [*8])
		else $error("select gap too short");
	a_mgmt_lock: assert property (psel && penable && !pready && pwrite && paddr == 12'h050 && !load_done
		|=> pready && pslverr)
		else $error("management write not refused during load");
	a_done_hold: assert property (load_done |=> load_done)
		else $error("done flag dropped");
	a_no_late_wr: assert property (load_done |-> !sram_wr.we)
		else $error("SRAM write after done");
	a_wr_range: assert property (sram_wr.we |-> sram_wr.addr <= 16'h001f
		|| (sram_wr.addr >= 16'h0400 && sram_wr.addr <= 16'h040f))
		else $error("SRAM write outside load ranges");
	a_fill_sig: assert property (sram_wr.we && sram_wr.addr == 16'h001c
		|-> sram_wr.data == (link_cfg.legacy_sig_select ? 16'h5757 : 16'h4242))
		else $error("legacy signature fill wrong");
	c_good: cover property ($rose(load_done) && link_cfg.sig_ok);
	c_bad: cover property ($rose(load_done) && !link_cfg.sig_ok);
	c_refused: cover property (pready && pslverr);
endmodule // eeprom_autoload_chk
bind eeprom_autoload_config eeprom_autoload_chk #(.APB_AW(APB_AW)) i_eeprom_autoload_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .cfgmem_select_n(cfgmem_select_n),
	.cfgmem_serial_clk(cfgmem_serial_clk), .cfgmem_serial_io_o(cfgmem_serial_io_o),
	.cfgmem_serial_io_oe(cfgmem_serial_io_oe), .sram_wr(sram_wr), .link_cfg(link_cfg),
	.load_done(load_done));
`default_nettype wire

// file: tb/cfgmem_model.sv
// Behavioural serial configuration memory.
// Assumes the bench resolves the shared pin with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module cfgmem_model (
	input wire logic sel_n, // Low while selected
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe
);
	logic [15:0] mem [256]; // Word image, filled by the bench
	logic [10:0] cmd = 11'h000; // Start, opcode, address
	logic [15:0] sh = 16'h0000; // Read shift register
	int n = 0; // Clocks seen in this frame
	initial dout = 1'b0;
	initial dout_oe = 1'b0;
	// Bits move on the rising clock; deselect aborts
	always @(posedge sclk or posedge sel_n) begin
		if (sel_n) begin
			n = 0;
			dout_oe = 1'b0; // Released line goes to the pull-up
		end else begin
			n = n + 1;
			if (n <= 11)
				cmd = {cmd[9:0], din};
			if (n == 11)
				sh = mem[cmd[7:0]];
			// Only a well-formed read gets an answer
			dout_oe = n >= 12 && n <= 28 && cmd[10:8] == 3'b110;
			dout = n > 12 && sh[15];
			if (n > 12)
				sh = {sh[14:0], 1'b0};
		end
	end
endmodule // cfgmem_model
`default_nettype wire

// file: tb/eeprom_autoload_config_tb.sv
// Bench for the autoloader: loads, bad signature, host access.
// Assumes the design package and memory model compile first.
`timescale 1ns/1ps
`default_nettype none
module eeprom_autoload_config_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [1:0] strap = 2'b00; // Power-on bus type pins
	logic [31:0] prdata, rd;
	logic pready, pslverr, sel_n, sclk, io_o, io_oe, io_w, m_o, m_oe, done, err;
	eeprom_autoload_pkg::sram_wr_t wr;
	eeprom_autoload_pkg::link_cfg_t cfg;
	logic [31:0] exq [$]; // Expected SRAM writes, {addr, data}
	logic chk_wr = 1'b1; // Off where write order is not modelled
	int failures = 0;
	int compares = 0;
	int seed = 32'h68dc_7a89;
	// 100 MHz clock
	initial forever #5 pclk = ~pclk;
	// Shared pin with pull-up
	assign io_w = io_oe ? io_o : (m_oe ? m_o : 1'b1);
	eeprom_autoload_config i_eeprom_autoload_config (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfgmem_select_n(sel_n), .cfgmem_serial_clk(sclk),
		.cfgmem_serial_io_o(io_o), .cfgmem_serial_io_oe(io_oe), .cfgmem_serial_io_i(io_w),
		.bus_type_strap(strap), .sram_wr(wr), .link_cfg(cfg), .load_done(done));
	cfgmem_model i_cfgmem_model (.sel_n(sel_n), .sclk(sclk), .din(io_w), .dout(m_o), .dout_oe(m_oe));
	// Verdict and end of run
	task automatic finish_test();
		$display("Compares %0d, failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			failures++;
			finish_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Reset with a fresh image, then wait for the load
	task automatic reload(input logic [15:0] s, input logic [15:0] n, input logic [15:0] c);
		int i;
		i_cfgmem_model.mem[0] = s;
		i_cfgmem_model.mem[1] = n;
		i_cfgmem_model.mem[2] = c;
		@(posedge pclk);
		presetn <= 1'b0;
		strap <= 2'($random(seed));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h050, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		chk(32'(done), 32'h0000_0000);
		for (i = 0; i < 30000 && done !== 1'b1; i++)
			@(posedge pclk);
		if (done !== 1'b1) begin
			failures++;
			finish_test();
		end else begin
			repeat (3) @(posedge pclk);
		end
	endtask
	// Each SRAM write takes the oldest expected entry
	always @(posedge pclk)
		if (wr.we === 1'b1 && chk_wr)
			chk({wr.addr, wr.data}, exq.size() > 0 ? exq.pop_front() : 32'hffff_ffff);
	// Main sequence
	initial begin
		logic [15:0] c;
		logic [15:0] w;
		int m;
		for (m = 3; m < 6; m++)
			i_cfgmem_model.mem[m] = 16'($random(seed));
		for (m = 0; m < 3; m++) begin
			w = i_cfgmem_model.mem[m + 3];
			exq.push_back({16'h0400 + 16'(2 * m), w});
			exq.push_back({16'(4 * m), w[7:0], w[7:0]});
			exq.push_back({16'(4 * m + 2), w[15:8], w[15:8]});
		end
		for (m = 0; m < 13; m++)
			exq.push_back(m < 6 ? {16'(16 + 2 * m), 16'h0000} : m < 8 ? {16'(16 + 2 * m), 16'h5757}
				: m < 12 ? {16'h0406 + 16'(2 * m - 16), 16'h0000} : 32'h040e_5757);
		reload(16'h5aa5, 16'h0006, 16'h0104);
		chk(32'(exq.size()), 32'h0000_0000);
		chk(32'(cfg), 32'({3'b001, 3'b001, strap, 1'b1}));
		$display("Test done: full load");
		apb(1'b1, 12'h054, 32'h0000_0020);
		repeat (3) @(posedge pclk);
		chk(32'({cfg.irq_type, cfg.irq_pol}), 32'h0000_0002);
		apb(1'b1, 12'h054, 32'h0000_0010);
		repeat (3) @(posedge pclk);
		chk(32'({cfg.irq_type, cfg.irq_pol}), 32'h0000_0001);
		apb(1'b1, 12'h050, 32'h0000_000c);
		repeat (2) @(posedge pclk);
		chk(32'({sel_n, io_oe, io_o}), 32'h0000_0003);
		apb(1'b0, 12'h050, 32'h0000_0000);
		chk(rd, 32'h0000_011c);
		apb(1'b1, 12'h050, 32'h0000_0001);
		chk(32'(err), 32'h0000_0000);
		apb(1'b0, 12'h058, 32'h0000_0000);
		chk(32'(rd[0]), 32'h0000_0001);
		apb(1'b0, 12'h0fc, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		$display("Test done: host access");
		reload(16'h5aa4, 16'h0006, 16'h0104);
		chk(32'({cfg.sig_ok, done}), 32'h0000_0001);
		$display("Test done: bad signature");
		chk_wr = 1'b0;
		for (m = 0; m < 8; m++) begin
			c = {5'h00, 3'(m), 2'b00, 2'($random(seed)), 1'b0, 1'($random(seed)), 2'b00};
			reload(16'h5aa5, 16'h0003, c);
			chk(32'({cfg.phy_mode, cfg.irq_type, cfg.irq_pol, cfg.legacy_sig_select}),
				32'({c[10:8], c[5:4], c[2]}));
			$display("Test done: mode %0d", m);
		end
		finish_test();
	end
endmodule // eeprom_autoload_config_tb
`default_nettype wire
